/* rtl/ilm_top.sv */
/*
  Interrupt level mask and global enable. Holds the level mask register and
  the system mode register in register set 1, applies the global enable
  instructions, the acceptance and return events, and presents one
  interrupt request to the core.
  Assumes the core's register port, instruction strobes and the peripheral
  requests all run on mclk_in; none of them needs synchronising.
*/
`timescale 1ns/1ps

`include "ilm_cfg.svh"

module ilm_top
(
    input  wire logic              mclk_in,
    input  wire logic              reset_in,
    input  wire ilm_pkg::ilm_byte_t reg_addr_in,
    input  wire logic              reg_set1_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    input  wire ilm_pkg::ilm_byte_t reg_wdata_in,
    input  wire ilm_pkg::ilm_src_t  src_req_in,
    input  wire ilm_pkg::ilm_src_t  src_en_in,
    input  wire ilm_pkg::ilm_levels_t ext_level_req_in,
    input  wire logic              global_enable_instr_in,
    input  wire logic              global_disable_instr_in,
    input  wire logic              return_from_service_instr_in,
    input  wire logic              irq_accept_in,
    output      ilm_pkg::ilm_byte_t reg_rdata_out,
    output      logic              irq_out,
    output      ilm_pkg::ilm_levels_t level_req_out,
    output      logic              global_irq_enable_out,
    output      logic              fast_irq_enable_out,
    output      ilm_pkg::ilm_level_t fast_level_select_out
);
    import ilm_pkg::*;

    // =====================================================================
    // source gate
    // =====================================================================
    ilm_src_if  src_bus ();

    assign src_bus.src_req = src_req_in;
    assign src_bus.src_en  = src_en_in;
    assign src_bus.ext_req = ext_level_req_in;

    ilm_src_gate u_gate
    (
        .mclk_in  (mclk_in),
        .reset_in (reset_in),
        .bus      (src_bus)
    );

    ilm_levels_t level_comb;

    assign level_comb = src_bus.level_req;

    // =====================================================================
    // register decode
    // =====================================================================
    ilm_sel_e    sel;
    logic        wr_mask;
    logic        wr_sym;
    logic        rd_any;

    assign sel = !reg_set1_in                       ? ILM_SEL_NONE :
                 (reg_addr_in == `ILM_ADDR_LEVEL_MASK) ? ILM_SEL_MASK :
                 (reg_addr_in == `ILM_ADDR_SYS_MODE)   ? ILM_SEL_SYM  :
                                                      ILM_SEL_NONE;

    assign wr_mask = reg_wr_in && (sel == ILM_SEL_MASK); // [R11]
    assign wr_sym  = reg_wr_in && (sel == ILM_SEL_SYM);  // [R5]
    assign rd_any  = reg_rd_in;

    // =====================================================================
    // level mask register
    // =====================================================================
    // deliberately not reset: software must load it before enabling
    ilm_levels_t level_mask_reg_r;
    ilm_levels_t level_mask_reg_nxt;

    assign level_mask_reg_nxt = wr_mask ? reg_wdata_in : level_mask_reg_r; // [R11]

    always_ff @(posedge mclk_in)
    begin
        level_mask_reg_r <= level_mask_reg_nxt; // [R12]
    end

    // =====================================================================
    // system mode register
    // =====================================================================
    logic        sym_gie_r;
    logic        sym_gie_nxt;
    logic        sym_fie_r;
    logic        sym_fie_nxt;
    ilm_level_t  sym_fls_r;
    ilm_level_t  sym_fls_nxt;

    // acceptance outranks everything so a taken interrupt always masks
    // the next one; return outranks the instructions it cannot overlap
    assign sym_gie_nxt = irq_accept_in                ? 1'b0 :       // [R17]
                         return_from_service_instr_in ? 1'b1 :       // [R17]
                         global_enable_instr_in       ? 1'b1 :       // [R8]
                         global_disable_instr_in      ? 1'b0 :       // [R8]
                         wr_sym ? reg_wdata_in[`ILM_SYM_GIE] : sym_gie_r;

    assign sym_fie_nxt = wr_sym ? reg_wdata_in[`ILM_SYM_FIE] : sym_fie_r;

    assign sym_fls_nxt = wr_sym ? reg_wdata_in[`ILM_SYM_FLS_HI:`ILM_SYM_FLS_LO]
                                : sym_fls_r;

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            sym_gie_r <= 1'b0; // [R6]
            sym_fie_r <= 1'b0; // [R6]
        end
        else
        begin
            sym_gie_r <= sym_gie_nxt;
            sym_fie_r <= sym_fie_nxt;
        end
    end

    // fast level field has no reset term
    always_ff @(posedge mclk_in)
    begin
        sym_fls_r <= sym_fls_nxt; // [R7]
    end

    // =====================================================================
    // read data
    // =====================================================================
    ilm_byte_t   sym_view;
    ilm_byte_t   rdata_nxt;
    ilm_byte_t   rdata_r;

    assign sym_view = {`ILM_SYM_RSVD_ZERO, sym_fls_r, sym_fie_r, sym_gie_r}; // [R5]

    assign rdata_nxt = !rd_any               ? rdata_r          :
                       (sel == ILM_SEL_MASK) ? level_mask_reg_r : // [R11]
                       (sel == ILM_SEL_SYM)  ? sym_view         :
                                               `ILM_BYTE_ZERO;

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
            rdata_r <= `ILM_BYTE_ZERO;
        else
            rdata_r <= rdata_nxt;
    end

    // =====================================================================
    // interrupt presentation
    // =====================================================================
    ilm_levels_t live_levels;
    logic        irq_nxt;
    logic        irq_r;
    ilm_levels_t level_req_r;
    ilm_level_t  fast_sel_nxt;
    ilm_level_t  fast_sel_r;

    // bit n of the mask gates level n; a clear bit blocks, a set bit passes
    assign live_levels = level_comb & level_mask_reg_r; // [R13] [R14] [R15]

    // uses the next global enable so the cycle after acceptance is quiet
    assign irq_nxt = sym_gie_nxt && (|live_levels); // [R16]

    // the undefined field is hidden while fast mode is off
    assign fast_sel_nxt = sym_fie_nxt ? sym_fls_nxt : `ILM_SYM_RSVD_ZERO;

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            irq_r       <= 1'b0;
            level_req_r <= '0;
            fast_sel_r  <= `ILM_SYM_RSVD_ZERO;
        end
        else
        begin
            irq_r       <= irq_nxt;
            level_req_r <= level_comb;
            fast_sel_r  <= fast_sel_nxt;
        end
    end

    assign reg_rdata_out         = rdata_r;
    assign irq_out               = irq_r;
    assign level_req_out         = level_req_r;
    assign global_irq_enable_out = sym_gie_r;
    assign fast_irq_enable_out   = sym_fie_r;
    assign fast_level_select_out = fast_sel_r;

    // =====================================================================
    // checks
    // =====================================================================
    AST_RESET_CLEARS: assert property (@(posedge mclk_in) // [R6]
        reset_in |=> (!global_irq_enable_out && !fast_irq_enable_out && !irq_out))
        else $error("enable bits not cleared by reset");

    AST_FIELD_KEEPS: assert property (@(posedge mclk_in) // [R7]
        (reset_in && !wr_sym) |=> $stable(sym_fls_r))
        else $error("fast level field altered by reset");

    AST_EI_SETS: assert property (@(posedge mclk_in) disable iff (reset_in) // [R8]
        (global_enable_instr_in && !irq_accept_in) |=> global_irq_enable_out)
        else $error("enable instruction did not set global enable");

    AST_DI_CLEARS: assert property (@(posedge mclk_in) disable iff (reset_in) // [R8]
        (global_disable_instr_in && !global_enable_instr_in && !return_from_service_instr_in)
        |=> !global_irq_enable_out [*1] ##0 !irq_out)
        else $error("disable instruction did not clear global enable");

    AST_ACCEPT_CLEARS: assert property (@(posedge mclk_in) disable iff (reset_in) // [R17]
        irq_accept_in |=> (!global_irq_enable_out && !irq_out))
        else $error("acceptance left global enable set");

    AST_RETURN_SETS: assert property (@(posedge mclk_in) disable iff (reset_in) // [R17]
        (return_from_service_instr_in && !irq_accept_in) |=> global_irq_enable_out)
        else $error("return did not restore global enable");

    AST_IRQ_CAUSE: assert property (@(posedge mclk_in) disable iff (reset_in) // [R16]
        irq_out |-> (global_irq_enable_out &&
                     (|($past(level_comb) & $past(level_mask_reg_r)))))
        else $error("interrupt presented without all enables");

    AST_MASK_BLOCKS: assert property (@(posedge mclk_in) disable iff (reset_in) // [R14]
        ((level_comb & level_mask_reg_r) == '0) |=> !irq_out)
        else $error("masked level reached the core");

    AST_MASK_PASSES: assert property (@(posedge mclk_in) disable iff (reset_in) // [R15]
        (sym_gie_nxt && (|(level_comb & level_mask_reg_r))) |=> irq_out)
        else $error("unmasked level with global enable not presented");

    AST_MASK_WRITE: assert property (@(posedge mclk_in) disable iff (reset_in) // [R11]
        wr_mask |=> (level_mask_reg_r == $past(reg_wdata_in)))
        else $error("level mask write lost");

    AST_MASK_READ: assert property (@(posedge mclk_in) disable iff (reset_in) // [R13]
        (reg_rd_in && sel == ILM_SEL_MASK) |=> (reg_rdata_out == $past(level_mask_reg_r)))
        else $error("level mask readback wrong");

    AST_SYM_READ: assert property (@(posedge mclk_in) disable iff (reset_in) // [R5]
        (reg_rd_in && sel == ILM_SEL_SYM) |=>
        (reg_rdata_out == {`ILM_SYM_RSVD_ZERO, $past(sym_fls_r),
                           $past(sym_fie_r), $past(sym_gie_r)}))
        else $error("system mode readback wrong");

    AST_UNMAPPED_ZERO: assert property (@(posedge mclk_in) disable iff (reset_in) // [R5]
        (reg_rd_in && sel == ILM_SEL_NONE) |=> (reg_rdata_out == `ILM_BYTE_ZERO))
        else $error("unmapped read not zero");

    AST_LEVEL_STATUS: assert property (@(posedge mclk_in) disable iff (reset_in) // [R18]
        1'b1 |=> (level_req_out == $past(level_comb)))
        else $error("level request status lags");
endmodule

/* rtl/ilm_cfg.svh */
/*
  Constants for the interrupt level mask and global enable block: register
  locations, field positions, source numbering and level assignment.
  Assumes it is included by its bare name, once per compilation unit.
*/
// Functional notes
// R1 - each source gated by its own enable
// R2 - both serial channels' events go to level five
// R3 - timer match/capture and overflow go to level three
// R4 - software disables globally before touching source enables
// R5 - system mode register holds global and fast controls
// R6 - reset clears global and fast enable bits
// R7 - fast level field keeps no reset value
// R8 - enable instruction sets, disable instruction clears bit
// R9 - software enables globally during initialization
// R10 - software prefers instructions over direct bit writes
// R11 - level mask register readable and writable
// R12 - level mask register keeps no reset value
// R13 - mask bit n controls level n
// R14 - mask bit zero blocks its level
// R15 - mask bit one lets its level through
// R16 - interrupt needs global, level and source enables
// R17 - acceptance clears global enable, return sets it
// R18 - enabled sources of a level are ORed
`ifndef ILM_CFG_SVH
`define ILM_CFG_SVH

`define ILM_NUM_LEVELS      8
`define ILM_NUM_SRC         6
`define ILM_LEVEL_BITS      3

`define ILM_ADDR_LEVEL_MASK 8'hdd
`define ILM_ADDR_SYS_MODE   8'hde

`define ILM_SYM_GIE         0
`define ILM_SYM_FIE         1
`define ILM_SYM_FLS_LO      2
`define ILM_SYM_FLS_HI      4
`define ILM_SYM_RSVD_ZERO   3'h0

`define ILM_SRC_CH0_TX      0
`define ILM_SRC_CH0_RX      1
`define ILM_SRC_CH1_TX      2
`define ILM_SRC_CH1_RX      3
`define ILM_SRC_TMR2_MATCH  4
`define ILM_SRC_TMR3_OVF    5

`define ILM_LVL_FIVE        3'h5
`define ILM_LVL_THREE       3'h3

`define ILM_BYTE_ZERO       8'h00

`endif

/* rtl/ilm_pkg.sv */
/*
  Types and level-assignment helpers shared by the top and the source gate.
  Assumes ilm_cfg.svh is on the include path.
*/
`include "ilm_cfg.svh"

package ilm_pkg;

    typedef logic [7:0]                    ilm_byte_t;
    typedef logic [`ILM_LEVEL_BITS-1:0]    ilm_level_t;
    typedef logic [`ILM_NUM_LEVELS-1:0]    ilm_levels_t;
    typedef logic [`ILM_NUM_SRC-1:0]       ilm_src_t;

    typedef enum logic [2:0]
    {
        ILM_SEL_NONE = 3'b001,
        ILM_SEL_MASK = 3'b010,
        ILM_SEL_SYM  = 3'b100
    } ilm_sel_e;

    // fixed wiring of each modelled source onto its level
    function automatic ilm_level_t ilm_src_level(input int s);
        case (s)
            `ILM_SRC_CH0_TX, `ILM_SRC_CH0_RX,
            `ILM_SRC_CH1_TX, `ILM_SRC_CH1_RX: return `ILM_LVL_FIVE;
            default:                          return `ILM_LVL_THREE;
        endcase
    endfunction

    function automatic ilm_src_t ilm_level_members(input ilm_level_t lvl);
        ilm_src_t m;
        m = '0;
        for (int s = 0; s < `ILM_NUM_SRC; s++)
        begin
            if (ilm_src_level(s) == lvl)
                m[s] = 1'b1;
        end
        return m;
    endfunction

endpackage

/* rtl/ilm_src_if.sv */
/*
  Bundle between the top and the source gate: raw source requests, their
  peripheral enables, pre-merged requests of unmodelled levels, and the
  combined level requests. Assumes one clock domain.
*/
`timescale 1ns/1ps

interface ilm_src_if;
    import ilm_pkg::*;

    ilm_src_t    src_req;
    ilm_src_t    src_en;
    ilm_levels_t ext_req;
    ilm_levels_t level_req;

    modport gate (input src_req, input src_en, input ext_req, output level_req);
    modport top  (output src_req, output src_en, output ext_req, input level_req);
endinterface

/* rtl/ilm_src_gate.sv */
/*
  Source gate: applies each source's peripheral enable and merges the enabled
  sources of every level into one level request. Purely combinational; the
  clock and reset only serve the checks.
  Assumes requests come from logic on the same clock.
*/
`timescale 1ns/1ps

`include "ilm_cfg.svh"

module ilm_src_gate
(
    input  wire logic  mclk_in,
    input  wire logic  reset_in,
    ilm_src_if.gate    bus
);
    import ilm_pkg::*;

    // =====================================================================
    // enable and merge
    // =====================================================================
    ilm_src_t    enabled_src;
    ilm_levels_t merged;

    assign enabled_src = bus.src_req & bus.src_en; // [R1]

    for (genvar l = 0; l < `ILM_NUM_LEVELS; l++)
    begin : g_lvl
        assign merged[l] = (|(enabled_src & ilm_level_members(ilm_level_t'(l))))
                         | bus.ext_req[l]; // [R18]
    end

    assign bus.level_req = merged; // [R2] [R3]

    // =====================================================================
    // checks
    // =====================================================================
    AST_LEVEL_FIVE: assert property (@(posedge mclk_in) disable iff (reset_in) // [R2]
        (|(bus.src_req[`ILM_SRC_CH1_RX:`ILM_SRC_CH0_TX] &
           bus.src_en[`ILM_SRC_CH1_RX:`ILM_SRC_CH0_TX])) |-> bus.level_req[`ILM_LVL_FIVE])
        else $error("serial channel request missing on level five");

    AST_LEVEL_THREE: assert property (@(posedge mclk_in) disable iff (reset_in) // [R3]
        (|(bus.src_req[`ILM_SRC_TMR3_OVF:`ILM_SRC_TMR2_MATCH] &
           bus.src_en[`ILM_SRC_TMR3_OVF:`ILM_SRC_TMR2_MATCH])) |-> bus.level_req[`ILM_LVL_THREE])
        else $error("timer request missing on level three");

    AST_OR_MERGE: assert property (@(posedge mclk_in) disable iff (reset_in) // [R18]
        (bus.src_en == '0 && bus.ext_req == '0) |-> bus.level_req == '0)
        else $error("level request raised with every source disabled");
endmodule

/* tb/ilm_core_model.sv */
/*
  Core-side model: takes a presented interrupt after a chosen wait and
  pulses the acceptance strobe once.
  Assumes it shares mclk_in and reset_in with the block.
*/
`timescale 1ns/1ps

module ilm_core_model
(
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    input  wire logic       irq_in,
    input  wire logic       ack_en_in,
    input  wire logic [3:0] wait_in,
    output      logic       accept_out
);
    logic [3:0] cnt_r;

    // ========================================
    // acceptance
    // a request that drops during the wait is never taken
    always_ff @(posedge mclk_in)
    begin
        accept_out <= 1'b0;
        if (reset_in || !irq_in || !ack_en_in || accept_out)
            cnt_r <= 4'h0;
        else if (cnt_r == wait_in)
            accept_out <= 1'b1;
        else
            cnt_r <= cnt_r + 4'h1;
    end
endmodule

/* tb/ilm_top_tb.sv */
/*
  Self-checking bench for ilm_top: registers, instructions, routing, masking
  and acceptance.
  Assumes ilm_pkg and the core model are compiled first.
*/
`timescale 1ns/1ps

module ilm_top_tb;
    import ilm_pkg::*;

    logic        mclk_in  = 1'b0;
    logic        reset_in = 1'b1;
    ilm_byte_t   addr     = 8'h00;
    ilm_byte_t   wdata    = 8'h00;
    ilm_byte_t   rdata;
    logic        set1     = 1'b0;
    logic        wr       = 1'b0;
    logic        rd       = 1'b0;
    ilm_src_t    src_req  = '0;
    ilm_src_t    src_en   = '0;
    ilm_levels_t ext_req  = '0;
    ilm_levels_t level_req;
    logic        en_i     = 1'b0;
    logic        dis_i    = 1'b0;
    logic        ret_i    = 1'b0;
    logic        acc_tb   = 1'b0;
    logic        ack_en   = 1'b0;
    logic [3:0]  wait_c   = 4'h0;
    logic        core_acc, irq, gie, fie;
    ilm_level_t  fls;
    int          err_total   = 0;
    int          checks_done = 0;
    int          cycles      = 0;

    always #5 mclk_in = ~mclk_in;

    ilm_top i_ilm_top (.mclk_in(mclk_in), .reset_in(reset_in), .reg_addr_in(addr),
        .reg_set1_in(set1), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
        .src_req_in(src_req), .src_en_in(src_en), .ext_level_req_in(ext_req),
        .global_enable_instr_in(en_i), .global_disable_instr_in(dis_i),
        .return_from_service_instr_in(ret_i), .irq_accept_in(acc_tb | core_acc),
        .reg_rdata_out(rdata), .irq_out(irq), .level_req_out(level_req),
        .global_irq_enable_out(gie), .fast_irq_enable_out(fie),
        .fast_level_select_out(fls));

    ilm_core_model i_ilm_core_model (.mclk_in(mclk_in), .reset_in(reset_in),
        .irq_in(irq), .ack_en_in(ack_en), .wait_in(wait_c), .accept_out(core_acc));

    // ========================================
    // helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic go;
        @(posedge mclk_in);
    endtask

    task automatic nxt;
        @(posedge mclk_in);
        #1;
    endtask

    task automatic wr_reg(input ilm_byte_t a, input ilm_byte_t d, input logic s);
        go;
        addr <= a;
        wdata <= d;
        set1 <= s;
        wr <= 1'b1;
        go;
        wr <= 1'b0;
    endtask

    // read data is taken one cycle after the strobe
    task automatic rd_chk(input ilm_byte_t a, input logic s, input ilm_byte_t exp);
        go;
        addr <= a;
        set1 <= s;
        rd <= 1'b1;
        go;
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // order of bits: accept, return, enable, disable
    task automatic strobe(input logic [3:0] v);
        go;
        {acc_tb, ret_i, en_i, dis_i} <= v;
        go;
        {acc_tb, ret_i, en_i, dis_i} <= 4'h0;
        #1;
    endtask

    // ========================================
    // scenarios
    task automatic t_reset;
        nxt;
        chk(gie, 1'b0);
        chk(fie, 1'b0);
        chk(irq, 1'b0);
        chk(level_req, 8'h00);
        wr_reg(8'hde, 8'h03, 1'b1);
        go;
        reset_in <= 1'b1;
        go;
        reset_in <= 1'b0;
        #1;
        chk(gie, 1'b0);
        chk(fie, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_regs;
        wr_reg(8'hdd, 8'ha5, 1'b1);
        rd_chk(8'hdd, 1'b1, 8'ha5);
        wr_reg(8'hdd, 8'h5a, 1'b0);
        rd_chk(8'hdd, 1'b1, 8'ha5);
        rd_chk(8'hdd, 1'b0, 8'h00);
        rd_chk(8'hdc, 1'b1, 8'h00);
        wr_reg(8'hde, 8'h1e, 1'b1);
        #1;
        chk(fls, 3'h7);
        chk(fie, 1'b1);
        chk(gie, 1'b0);
        rd_chk(8'hde, 1'b1, 8'h1e);
        wr_reg(8'hde, 8'hff, 1'b1);
        rd_chk(8'hde, 1'b1, 8'h1f);
        wr_reg(8'hde, 8'h00, 1'b1);
        $display("test registers done");
    endtask

    task automatic t_instr;
        logic [3:0] sv [6];
        logic       ge [6];
        sv = '{4'h2, 4'h1, 4'h3, 4'hc, 4'h4, 4'h8};
        ge = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 6; i++)
        begin
            strobe(sv[i]);
            chk(gie, ge[i]);
        end
        $display("test instructions done");
    endtask

    task automatic t_route;
        for (int s = 0; s < 6; s++)
        begin
            go;
            src_en <= ilm_src_t'(1 << s);
            src_req <= ilm_src_t'(1 << s);
            nxt;
            chk(level_req, (s < 4) ? 8'h20 : 8'h08);
            go;
            src_en <= '0;
            nxt;
            chk(level_req, 8'h00);
        end
        go;
        src_en <= 6'h3f;
        src_req <= 6'h11;
        nxt;
        chk(level_req, 8'h28);
        go;
        src_req <= '0;
        for (int n = 0; n < 8; n++)
        begin
            go;
            ext_req <= ilm_levels_t'(1 << n);
            nxt;
            chk(level_req, ilm_levels_t'(1 << n));
        end
        $display("test routing done");
    endtask

    task automatic t_mask;
        // global enable by instruction before loading the mask
        strobe(4'h2);
        for (int n = 0; n < 8; n++)
        begin
            go;
            ext_req <= ilm_levels_t'(1 << n);
            wr_reg(8'hdd, ~ilm_byte_t'(1 << n), 1'b1);
            nxt;
            chk(irq, 1'b0);
            wr_reg(8'hdd, ilm_byte_t'(1 << n), 1'b1);
            nxt;
            chk(irq, 1'b1);
        end
        strobe(4'h1);
        chk(irq, 1'b0);
        go;
        ext_req <= '0;
        $display("test masking done");
    endtask

    task automatic t_accept;
        int k;
        wr_reg(8'hdd, 8'h20, 1'b1);
        // source enable changed while globally disabled
        src_en <= 6'h01;
        src_req <= 6'h01;
        strobe(4'h2);
        go;
        wait_c <= 4'h3;
        ack_en <= 1'b1;
        k = 0;
        while (gie === 1'b1 && k < 20)
        begin
            nxt;
            k++;
        end
        chk(gie, 1'b0);
        chk(irq, 1'b0);
        go;
        ack_en <= 1'b0;
        strobe(4'h4);
        chk(gie, 1'b1);
        chk(irq, 1'b1);
        go;
        src_req <= '0;
        $display("test acceptance done");
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // the whole run takes under two hundred cycles
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            print_verdict;
        end
    end

    initial
    begin
        repeat (12) @(posedge mclk_in);
        reset_in <= 1'b0;
        t_reset;
        t_regs;
        t_instr;
        t_route;
        t_mask;
        t_accept;
        print_verdict;
    end
endmodule
